// ===== rtl/csb_core_glue.sv
// core boundary glue: straps, endianness, interrupt sampling, bus strobe, trace sideband
// assumes straps valid while reset is low; inputs synchronous to sys_clk
`timescale 1ns/10ps
module csb_core_glue #(
	parameter int unsigned DATA_W = 32,
	parameter int unsigned WP_NUM = 2
) (
	input wire logic sys_clk,
	input wire logic resetn,
	// axi4-lite slave
	input wire logic [csb_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [csb_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// straps and configuration
	input wire logic ram_enable_strap,
	input wire logic vector_base_strap,
	output logic ram_enabled,
	output logic [31:0] vector_base,
	output logic endianness_out,
	// interrupts
	input wire logic fast_irq_n,
	input wire logic normal_irq_n,
	output logic fast_irq_req,
	output logic normal_irq_req,
	// bus side
	input wire logic bus_clock_strobe,
	input wire logic [31:0] bus_rdata,
	input wire logic bus_ready,
	output csb_pkg::csb_ahbout_s bus_out,
	// trace side
	input wire logic trace_output_enable,
	input wire logic trace_buffer_full,
	output csb_pkg::csb_trace_s trace_out,
	// identification
	input wire logic [31:0] jtag_identification_input,
	input wire logic id_shift,
	input wire logic id_capture,
	output logic test_data_output
);
	initial begin
		if (DATA_W != 32) $error("csb_core_glue: only 32-bit data supported");
		if (WP_NUM != 2) $error("csb_core_glue: exactly two watchpoints supported");
	end

	// ---------- register bus ----------
	logic [31:0] ctrl_r;
	logic [31:0] procId_r;
	logic [31:0] wpAddr_r [WP_NUM];
	logic [31:0] wpMask_r [WP_NUM];
	logic [2:0] trcCmd_r;
	logic [31:0] tData_r;
	logic [31:0] busWr_r;
	logic [31:0] busRd_r;
	logic busPend_r;
	logic [csb_pkg::ADDR_W-1:0] awAddr_r;
	logic awHeld_r;
	logic [31:0] wData_r;
	logic wHeld_r;
	logic procWr_r;
	logic trcWr_r;
	logic ramEn_r;
	logic vecHi_r;
	logic straps_r;
	logic fiqS_r;
	logic irqS_r;

	wire awTake = s_axi_awvalid && s_axi_awready;
	wire wTake = s_axi_wvalid && s_axi_wready;
	wire haveAw = awHeld_r || awTake;
	wire haveW = wHeld_r || wTake;
	wire [csb_pkg::ADDR_W-1:0] wrAddr = awHeld_r ? awAddr_r : s_axi_awaddr;
	wire [31:0] wrData = wHeld_r ? wData_r : s_axi_wdata;
	wire doWrite = haveAw && haveW && !s_axi_bvalid;
	wire [31:0] strbMask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
		{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

	wire selCtrl = wrAddr == csb_pkg::CTRL_OFS;
	wire selProc = wrAddr == csb_pkg::PROCID_OFS;
	wire selWa0 = wrAddr == csb_pkg::WP0ADDR_OFS;
	wire selWm0 = wrAddr == csb_pkg::WP0MASK_OFS;
	wire selWa1 = wrAddr == csb_pkg::WP1ADDR_OFS;
	wire selWm1 = wrAddr == csb_pkg::WP1MASK_OFS;
	wire selTrc = wrAddr == csb_pkg::TRACE_OFS;
	wire selTd = wrAddr == csb_pkg::TDATA_OFS;
	wire selBw = wrAddr == csb_pkg::BUSWR_OFS;
	wire wrMapped = selCtrl || selProc || selWa0 || selWm0 || selWa1 || selWm1
		|| selTrc || selTd || selBw;
	// wstrb masks the write data in the cycle it arrives; held data was masked when captured
	wire [31:0] wMerge = wrData & strbMask;

	assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
	assign s_axi_wready = !wHeld_r && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			awAddr_r <= '0;
			wData_r <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= csb_pkg::RESP_OKAY;
		end else begin
			if (awTake && !doWrite) begin
				awHeld_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end
			if (wTake && !doWrite) begin
				wHeld_r <= 1'b1;
				wData_r <= s_axi_wdata & strbMask;
			end
			if (doWrite) begin
				awHeld_r <= 1'b0;
				wHeld_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wrMapped ? csb_pkg::RESP_OKAY : csb_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	wire [31:0] wVal = wHeld_r ? wData_r : wMerge;

	// software-visible registers; ctrl bit for endianness is static configuration [R7]
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_r <= csb_pkg::CTRL_RST;
			procId_r <= '0;
			wpAddr_r <= '{default: '0};
			wpMask_r <= '{default: '0};
			tData_r <= '0;
			procWr_r <= 1'b0;
			trcWr_r <= 1'b0;
			trcCmd_r <= '0;
		end else begin
			procWr_r <= doWrite && selProc;
			trcWr_r <= doWrite && selTrc;
			if (doWrite && selCtrl) ctrl_r <= wVal;
			if (doWrite && selProc) procId_r <= wVal;
			if (doWrite && selWa0) wpAddr_r[0] <= wVal;
			if (doWrite && selWm0) wpMask_r[0] <= wVal;
			if (doWrite && selWa1) wpAddr_r[1] <= wVal;
			if (doWrite && selWm1) wpMask_r[1] <= wVal;
			if (doWrite && selTd) tData_r <= wVal;
			if (doWrite && selTrc) trcCmd_r <= wVal[2:0];
		end
	end

	// ---------- straps: captured while reset is low and on the first edge after release, frozen after ----------
	// async reset clears the flag; the clock samples the pins until the first edge after release
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			straps_r <= 1'b0;
		end else begin
			straps_r <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!straps_r) begin
			ramEn_r <= ram_enable_strap; // R4
			vecHi_r <= vector_base_strap; // R5
		end
	end

	assign ram_enabled = ramEn_r; // R4
	assign vector_base = vecHi_r ? csb_pkg::VEC_HIGH_BASE : csb_pkg::VEC_LOW_BASE; // R5
	assign endianness_out = ctrl_r[csb_pkg::CTRL_BIGEND_BIT]; // R6

	// ---------- interrupts ----------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			fiqS_r <= 1'b0;
			irqS_r <= 1'b0;
		end else begin
			fiqS_r <= !fast_irq_n; // R8
			irqS_r <= !normal_irq_n; // R8
		end
	end
	assign fast_irq_req = fiqS_r;
	assign normal_irq_req = irqS_r;

	// ---------- bus side, outputs and read data advanced only on strobe edges; request loaded on a write to BUSWR_OFS ----------
	// plain edge-triggered flops, no dynamic state, so a stretched clock loses nothing R3
	wire busDone = busPend_r && bus_ready && bus_clock_strobe; // R17
	wire busStart = doWrite && selBw;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			bus_out <= '0;
			busPend_r <= 1'b0;
			busWr_r <= '0;
			busRd_r <= '0;
		end else begin
			if (busStart) begin
				busWr_r <= wVal;
				busPend_r <= 1'b1;
			end
			if (bus_clock_strobe) begin // R2
				bus_out.trans <= busPend_r && !busDone;
				bus_out.write <= busPend_r && !busDone;
				bus_out.addr <= wpAddr_r[0];
				bus_out.wdata <= busWr_r;
			end
			if (busDone) begin
				busRd_r <= bus_rdata; // R17
				if (!busStart) busPend_r <= 1'b0;
			end
		end
	end

	// ---------- watchpoints: compare regardless of enable bit ----------
	logic [WP_NUM-1:0] wpHit;
	wire [31:0] cmpBus = trcCmd_r[csb_pkg::TRC_STORE_BIT] ? tData_r : busRd_r;
	always_comb begin
		for (int i = 0; i < WP_NUM; i++) begin
			wpHit[i] = ((cmpBus ^ wpAddr_r[i]) & ~wpMask_r[i]) == 32'h0000_0000; // R11
		end
	end

	// ---------- trace sideband, one stage behind internal signals ----------
	wire trcValid = trcWr_r && trcCmd_r[csb_pkg::TRC_VALID_BIT];
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			trace_out <= '0;
		end else if (trace_output_enable) begin // R16
			trace_out.instrValid <= trcValid; // R13
			trace_out.procIdWr <= procWr_r; // R10
			trace_out.procId <= procId_r; // R9
			trace_out.wpMatch <= wpHit; // R11
			if (trcWr_r && trcCmd_r[csb_pkg::TRC_LOAD_BIT]) trace_out.readData <= busRd_r; // R14
			if (trcWr_r && trcCmd_r[csb_pkg::TRC_STORE_BIT]) trace_out.writeData <= tData_r; // R14
		end else begin
			trace_out <= '0;
		end
	end

	// ---------- identification shift register ----------
	logic [31:0] idSh_r;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			idSh_r <= '0;
		end else if (id_capture) begin
			idSh_r <= jtag_identification_input; // R15
		end else if (id_shift) begin
			idSh_r <= {1'b0, idSh_r[31:1]};
		end
	end
	assign test_data_output = idSh_r[0]; // R15

	// ---------- register read ----------
	wire [31:0] statVal = {26'h0, trace_buffer_full, busPend_r, irqS_r, fiqS_r,
		vecHi_r, ramEn_r};
	logic [31:0] rdMux;
	logic rdOk;
	always_comb begin
		rdOk = 1'b1;
		case (s_axi_araddr)
			csb_pkg::CTRL_OFS: rdMux = ctrl_r;
			csb_pkg::STAT_OFS: rdMux = statVal;
			csb_pkg::PROCID_OFS: rdMux = procId_r;
			csb_pkg::WP0ADDR_OFS: rdMux = wpAddr_r[0];
			csb_pkg::WP0MASK_OFS: rdMux = wpMask_r[0];
			csb_pkg::WP1ADDR_OFS: rdMux = wpAddr_r[1];
			csb_pkg::WP1MASK_OFS: rdMux = wpMask_r[1];
			csb_pkg::TRACE_OFS: rdMux = {29'h0, trcCmd_r};
			csb_pkg::TDATA_OFS: rdMux = tData_r;
			csb_pkg::BUSRD_OFS: rdMux = busRd_r;
			csb_pkg::BUSWR_OFS: rdMux = busWr_r;
			default: begin
				rdMux = 32'h0000_0000;
				rdOk = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= csb_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdMux;
			s_axi_rresp <= rdOk ? csb_pkg::RESP_OKAY : csb_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// ===== rtl/csb_pkg.sv
// constants, carriers and register map of the core boundary glue block
// assumes one core clock, asynchronous active-low reset, AXI4-Lite register access
//
// Operation
// [R1] integrator pulses bus clock strobe for one core clock per bus clock edge
// [R2] bus-side outputs change only on edges where the bus clock strobe is high
// [R3] state survives a stretched clock held high or low
// [R4] ram enable strap sampled in reset; high enables both RAMs afterwards
// [R5] vector base strap sampled in reset; low gives base zero, high gives top base
// [R6] endianness output high for big-endian, low for little-endian
// [R7] software keeps endianness fixed or changes it by careful sequence
// [R8] fast and normal interrupt inputs active low, sampled on the core clock
// [R9] current process identifier presented as 32-bit trace output
// [R10] process identifier write strobe pulses on each identifier write
// [R11] two watchpoint match outputs follow comparisons regardless of enable bits
// [R12] trace unit drives buffer-full input; tied low when no trace unit
// [R13] trace instruction valid output marks instruction valid for capture
// [R14] 32-bit read and write data buses carry load and store data to trace
// [R15] identification input supplies value shifted out after identify instruction
// [R16] with trace enable high, trace outputs registered one stage from internal signals
// [R17] bus-side inputs sampled only on edges where bus clock strobe is high
package csb_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] STAT_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] PROCID_OFS = 8'h08;
	localparam logic [ADDR_W-1:0] WP0ADDR_OFS = 8'h0C;
	localparam logic [ADDR_W-1:0] WP0MASK_OFS = 8'h10;
	localparam logic [ADDR_W-1:0] WP1ADDR_OFS = 8'h14;
	localparam logic [ADDR_W-1:0] WP1MASK_OFS = 8'h18;
	localparam logic [ADDR_W-1:0] TRACE_OFS = 8'h1C;
	localparam logic [ADDR_W-1:0] TDATA_OFS = 8'h20;
	localparam logic [ADDR_W-1:0] BUSRD_OFS = 8'h24;
	localparam logic [ADDR_W-1:0] BUSWR_OFS = 8'h28;
	// control bit positions
	localparam int unsigned CTRL_BIGEND_BIT = 0;
	localparam int unsigned CTRL_WP0EN_BIT = 1;
	localparam int unsigned CTRL_WP1EN_BIT = 2;
	localparam int unsigned CTRL_IDSEL_BIT = 3;
	// trace command bit positions
	localparam int unsigned TRC_VALID_BIT = 0;
	localparam int unsigned TRC_LOAD_BIT = 1;
	localparam int unsigned TRC_STORE_BIT = 2;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] VEC_LOW_BASE = 32'h0000_0000;
	localparam logic [31:0] VEC_HIGH_BASE = 32'hFFFF_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// sideband toward the trace unit
	typedef struct packed {
		logic instrValid;
		logic procIdWr;
		logic [1:0] wpMatch;
		logic [31:0] procId;
		logic [31:0] readData;
		logic [31:0] writeData;
	} csb_trace_s;

	// bus-side request outputs
	typedef struct packed {
		logic trans;
		logic write;
		logic [31:0] addr;
		logic [31:0] wdata;
	} csb_ahbout_s;
endpackage

// ===== tb/csb_bus_partner.sv
// bus-side partner: strobe source and slow slave
// assumes stall asks for wait states; reads answer addr xor key
`timescale 1ns/10ps
module csb_bus_partner #(
	parameter int unsigned DIV = 3,
	parameter logic [31:0] KEY = 32'h5A5A5A5A
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic stall,
	input wire csb_pkg::csb_ahbout_s bus_out,
	output logic bus_clock_strobe,
	output logic [31:0] bus_rdata,
	output logic bus_ready
);
	localparam logic [7:0] LAST = 8'(DIV - 1);
	logic [7:0] divCnt_r;

	// strobe runs free; the core must hold its outputs between strobes anyway
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			divCnt_r <= 8'h00;
			bus_clock_strobe <= 1'b0;
			bus_rdata <= 32'h0000_0000;
			bus_ready <= 1'b0;
		end else begin
			divCnt_r <= (divCnt_r == LAST) ? 8'h00 : divCnt_r + 8'h01;
			bus_clock_strobe <= divCnt_r == LAST;
			bus_ready <= !stall;
			bus_rdata <= bus_out.addr ^ KEY;
		end
	end
endmodule

// ===== tb/csb_glue_props.sv
// checker for csb_core_glue, bound to every instance
// assumes one clock sys_clk and asynchronous active-low resetn
`timescale 1ns/10ps
module csb_glue_props (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic bus_clock_strobe,
	input wire logic fast_irq_n,
	input wire logic normal_irq_n,
	input wire logic fast_irq_req,
	input wire logic normal_irq_req,
	input wire logic ram_enabled,
	input wire logic [31:0] vector_base,
	input wire logic trace_output_enable,
	input wire logic id_capture,
	input wire logic [31:0] jtag_identification_input,
	input wire logic test_data_output,
	input wire csb_pkg::csb_ahbout_s bus_out,
	input wire csb_pkg::csb_trace_s trace_out
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// straps may still load on the first edge after release
	sequence s_up3;
		resetn ##1 resetn ##1 resetn;
	endsequence
	sequence s_traceOff;
		!trace_output_enable ##1 !trace_output_enable;
	endsequence
	property p_busHold;
		!$stable(bus_out) |-> $past(bus_clock_strobe);
	endproperty
	a_busHold: assert property (p_busHold) else $error("bus moved off strobe");
	property p_strapHold;
		s_up3 |-> $stable(vector_base) && $stable(ram_enabled);
	endproperty
	a_strapHold: assert property (p_strapHold) else $error("strap result moved");
	property p_fiq;
		$fell(fast_irq_n) |=> $rose(fast_irq_req);
	endproperty
	a_fiq: assert property (p_fiq) else $error("fast request late");
	property p_normal_irq_n;
		normal_irq_n |=> !normal_irq_req;
	endproperty
	a_normal_irq_n: assert property (p_normal_irq_n) else $error("normal request while high");
	property p_traceOff;
		s_traceOff |-> trace_out == '0;
	endproperty
	a_traceOff: assert property (p_traceOff) else $error("trace driven when off");
	property p_ivPulse;
		trace_out.instrValid |=> !trace_out.instrValid;
	endproperty
	a_ivPulse: assert property (p_ivPulse) else $error("valid pulse too long");
	property p_pwPulse;
		trace_out.procIdWr |=> !trace_out.procIdWr;
	endproperty
	a_pwPulse: assert property (p_pwPulse) else $error("id strobe too long");
	property p_idCap;
		id_capture |=> test_data_output == $past(jtag_identification_input[0]);
	endproperty
	a_idCap: assert property (p_idCap) else $error("capture bit wrong");
endmodule
bind csb_core_glue csb_glue_props u_csb_glue_props (.*);

// ===== tb/tb_top.sv
// self-checking bench for csb_core_glue
// assumes the bus partner model answers the bus side
`timescale 1ns/10ps
module tb_top;
	localparam logic [31:0] KEY = 32'h5A5A_5A5A;
	logic sys_clk = 1'b0;
	logic resetn;
	logic [7:0] s_axi_awaddr;
	logic s_axi_awvalid;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_wvalid;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready;
	logic [7:0] s_axi_araddr;
	logic s_axi_arvalid;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready;
	logic ram_enable_strap;
	logic vector_base_strap;
	logic ram_enabled;
	logic [31:0] vector_base;
	logic endianness_out;
	logic fast_irq_n;
	logic normal_irq_n;
	logic fast_irq_req;
	logic normal_irq_req;
	logic bus_clock_strobe;
	logic [31:0] bus_rdata;
	logic bus_ready;
	csb_pkg::csb_ahbout_s bus_out;
	logic trace_output_enable;
	logic trace_buffer_full;
	csb_pkg::csb_trace_s trace_out;
	logic [31:0] jtag_identification_input;
	logic id_shift;
	logic id_capture;
	logic test_data_output;
	logic stall;
	int fails = 0;
	int compares = 0;
	logic [31:0] lfsr = 32'h4A86_F5FF;

	always #12.5 sys_clk = ~sys_clk;

	csb_core_glue u_csb_core_glue (.sys_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.ram_enable_strap, .vector_base_strap, .ram_enabled, .vector_base, .endianness_out,
		.fast_irq_n, .normal_irq_n, .fast_irq_req, .normal_irq_req, .bus_clock_strobe,
		.bus_rdata, .bus_ready, .bus_out, .trace_output_enable, .trace_buffer_full,
		.trace_out, .jtag_identification_input, .id_shift, .id_capture, .test_data_output);

	csb_bus_partner #(.DIV(3), .KEY(KEY)) u_csb_bus_partner (.sys_clk, .resetn, .stall,
		.bus_out, .bus_clock_strobe, .bus_rdata, .bus_ready);

	function automatic logic [31:0] lfsrNext(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic rnd();
		lfsr = lfsrNext(lfsr);
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic results();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic axiWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 50);
		s_axi_bready <= 1'b0;
		r = s_axi_bresp;
		if (n >= 50) fails++;
	endtask

	task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 50);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		r = s_axi_rresp;
		if (n >= 50) fails++;
	endtask

	initial begin
		#(25ns * 20000);
		fails++;
		results();
	end

	initial begin
		logic [31:0] v;
		logic [31:0] t;
		logic [31:0] got;
		logic [1:0] rsp;
		int n;
		resetn = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'h0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 8'h00;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		ram_enable_strap = 1'b0;
		vector_base_strap = 1'b0;
		fast_irq_n = 1'b1;
		normal_irq_n = 1'b1;
		trace_output_enable = 1'b0;
		trace_buffer_full = 1'b0;
		jtag_identification_input = 32'h0000_0000;
		id_shift = 1'b0;
		id_capture = 1'b0;
		stall = 1'b0;
		// second pass is a mid-run reset with the opposite straps
		for (int k = 0; k < 2; k++) begin
			@(posedge sys_clk);
			resetn <= 1'b0;
			ram_enable_strap <= k == 0;
			vector_base_strap <= k == 1;
			repeat (4) @(posedge sys_clk);
			resetn <= 1'b1;
			repeat (2) @(posedge sys_clk);
			ram_enable_strap <= k == 1;
			vector_base_strap <= k == 0;
			repeat (3) @(posedge sys_clk);
			@(negedge sys_clk);
			check(32'(ram_enabled), 32'(k == 0), "ram enable");
			check(vector_base, k ? csb_pkg::VEC_HIGH_BASE : csb_pkg::VEC_LOW_BASE, "vecs");
			axiRd(csb_pkg::STAT_OFS, got, rsp);
			check(got[1:0], {30'h0, k == 1, k == 0}, "strap status");
			$display("test straps %0d done", k);
		end
		rnd();
		v = lfsr;
		axiWr(csb_pkg::CTRL_OFS, {31'h0, v[0]}, rsp);
		@(negedge sys_clk);
		check(32'(endianness_out), 32'(v[0]), "endianness");
		for (int i = 0; i < 4; i++) begin
			rnd();
			axiWr(csb_pkg::WP1ADDR_OFS, lfsr, rsp);
			axiRd(csb_pkg::WP1ADDR_OFS, got, rsp);
			check(got, lfsr, "readback");
		end
		axiWr(8'hFC, lfsr, rsp);
		check(32'(rsp), 32'(csb_pkg::RESP_SLVERR), "unmapped write");
		axiRd(8'hFC, got, rsp);
		check(32'(rsp), 32'(csb_pkg::RESP_SLVERR), "unmapped read");
		$display("test registers done");
		@(posedge sys_clk);
		fast_irq_n <= 1'b0;
		@(posedge sys_clk);
		normal_irq_n <= 1'b0;
		@(negedge sys_clk);
		check(32'(fast_irq_req), 32'h1, "fast request");
		check(32'(normal_irq_req), 32'h0, "normal request early");
		@(negedge sys_clk);
		check(32'(normal_irq_req), 32'h1, "normal request");
		@(posedge sys_clk);
		fast_irq_n <= 1'b1;
		normal_irq_n <= 1'b1;
		trace_buffer_full <= 1'b1;
		axiRd(csb_pkg::STAT_OFS, got, rsp);
		check(32'(got[5]), 32'h1, "buffer full");
		trace_buffer_full <= 1'b0;
		$display("test interrupts done");
		@(posedge sys_clk);
		trace_output_enable <= 1'b1;
		rnd();
		v = lfsr;
		axiWr(csb_pkg::PROCID_OFS, v, rsp);
		@(negedge sys_clk);
		check(32'(trace_out.procIdWr), 32'h1, "id strobe");
		check(trace_out.procId, v, "process id");
		@(negedge sys_clk);
		check(32'(trace_out.procIdWr), 32'h0, "id strobe end");
		rnd();
		t = lfsr;
		axiWr(csb_pkg::TDATA_OFS, t, rsp);
		axiWr(csb_pkg::WP0ADDR_OFS, t, rsp);
		axiWr(csb_pkg::WP1ADDR_OFS, ~t, rsp);
		axiWr(csb_pkg::WP1MASK_OFS, 32'h0000_0000, rsp);
		axiWr(csb_pkg::TRACE_OFS, 32'h0000_0005, rsp);
		@(negedge sys_clk);
		check(32'(trace_out.instrValid), 32'h1, "instr valid");
		check(trace_out.writeData, t, "write data");
		@(negedge sys_clk);
		check(32'(trace_out.wpMatch), 32'h1, "match one");
		axiWr(csb_pkg::WP1MASK_OFS, 32'hFFFF_FFFF, rsp);
		repeat (2) @(negedge sys_clk);
		check(32'(trace_out.wpMatch), 32'h3, "match both");
		$display("test trace done");
		@(posedge sys_clk);
		stall <= 1'b1;
		rnd();
		v = lfsr;
		axiWr(csb_pkg::BUSWR_OFS, v, rsp);
		repeat (10) @(negedge sys_clk);
		check(32'(bus_out.trans), 32'h1, "bus request");
		check(bus_out.wdata, v, "bus wdata");
		check(bus_out.addr, t, "bus addr");
		@(posedge sys_clk);
		stall <= 1'b0;
		n = 0;
		do begin
			axiRd(csb_pkg::STAT_OFS, got, rsp);
			n++;
		end while (got[4] && n < 100);
		check(32'(got[4]), 32'h0, "bus done");
		axiRd(csb_pkg::BUSRD_OFS, got, rsp);
		check(got, t ^ KEY, "bus read data");
		axiWr(csb_pkg::TRACE_OFS, 32'h0000_0003, rsp);
		@(negedge sys_clk);
		check(trace_out.readData, t ^ KEY, "read data");
		@(posedge sys_clk);
		trace_output_enable <= 1'b0;
		repeat (2) @(negedge sys_clk);
		check(trace_out.procId, 32'h0000_0000, "trace off");
		$display("test bus done");
		@(posedge sys_clk);
		rnd();
		jtag_identification_input <= lfsr;
		id_capture <= 1'b1;
		@(posedge sys_clk);
		id_capture <= 1'b0;
		id_shift <= 1'b1;
		for (int i = 0; i < 32; i++) begin
			@(negedge sys_clk);
			got[i] = test_data_output;
			@(posedge sys_clk);
		end
		id_shift <= 1'b0;
		check(got, lfsr, "identification");
		$display("test identification done");
		results();
	end
endmodule
